// File: rtl/pwr_ctrl_regs.sv
// Notes on behaviour
// - Writing one to the low-power task selects the variable-latency sub-mode.
// - Power-fail event reads 1 once it occurred; writable; resets to 0.
// - Sleep entered and exited events set on sleep entry and exit.
// - Bus power arrived event sets when bus supply voltage appears.
// - Bus power departed event sets when bus supply voltage is removed.
// - USB regulator ready event sets when the internal supply is ready.
// - Interrupt enable set: write one enables, zero no effect, reads enables.
// - Interrupt enable clear: write one disables; reads enables; reset off.
// - Reset-cause flags accumulate across resets until software clears them.
// - Writing one to a reset-cause flag clears it, zero leaves it.
// - No reset-cause flag set means power-on or brownout reset.
// - Pin reset and watchdog reset set their own cause flags.
// - Soft reset and lockup reset set their own cause flags.
// - GPIO sense wake from System OFF sets the GPIO wake flag.
// - Debug-mode wake from System OFF sets the debug wake flag.
// - Bus supply wake from System OFF sets its own flag.
// - Memory status has two blocks, each pairing section 0 of two memories.
// - A block bit reads 1 while any of its sections is powered on.
// - Writing one to the System OFF register enters System OFF.
// - Fail warning enable bit: 0 disables, 1 enables; resets to 0.
// - Threshold codes 4 to 15 mean 1.7 V to 2.8 V in 100 mV steps.
// - The fixed-latency task selects the constant-latency sub-mode.
// - After reset the block is in the low-power sub-mode.
//
// Local design decision: the plain strobed port.
module pwr_ctrl_regs
    import pwr_ctrl_pkg::*;
(
    input  wire logic              I_SYS_CLK,
    input  wire logic              I_RST_N,
    input  wire logic              I_CLK_EN,
    input  wire logic [ADDR_W-1:0] I_ADDR,
    input  wire logic [31:0]       I_WDATA,
    input  wire logic              I_WR,
    input  wire logic              I_RD,
    input  wire logic              I_PWR_FAIL,
    input  wire logic              I_SLEEP_ENTER,
    input  wire logic              I_SLEEP_EXIT,
    input  wire logic              I_VBUS_PRESENT,
    input  wire logic              I_USB_REG_READY,
    input  wire logic              I_RST_PIN,
    input  wire logic              I_RST_WATCHDOG,
    input  wire logic              I_RST_SOFT,
    input  wire logic              I_RST_LOCKUP,
    input  wire logic              I_WAKE_GPIO,
    input  wire logic              I_WAKE_DEBUG,
    input  wire logic              I_WAKE_VBUS,
    input  wire logic [3:0]        I_MEM_SECTION_ON,
    output logic      [31:0]       O_RDATA,
    output logic                   O_IRQ,
    output logic                   O_FIXED_LATENCY,
    output logic                   O_SYSTEM_OFF,
    output logic                   O_PF_ENABLE,
    output logic      [3:0]        O_PF_THRESHOLD,
    output logic      [3:0]        O_PF_THRESHOLD_HV
);

    // Previous supply levels feed edge detection for the bus and regulator-ready events.
    typedef struct packed {
        logic [31:0]           rdata;
        logic [NUM_EVENTS-1:0] events;
        logic [NUM_EVENTS-1:0] int_en;
        logic [31:0]           reset_cause;
        logic [31:0]           pf_cfg;
        logic                  fixed_latency;
        logic                  system_off;
        logic                  irq;
        logic                  vbus_prev;
        logic                  usb_rdy_prev;
    } state_t;

    state_t st;
    state_t next_st;

    logic [NUM_EVENTS-1:0] ev_hit;
    logic [NUM_EVENTS-1:0] ev_wr;
    logic [NUM_EVENTS-1:0] ev_next;
    logic [31:0]           rc_set;
    logic [1:0]            mem_block_on;
    logic                  wr_one;

    assign wr_one = I_WDATA[0];

    // Events in register order: fail, sleep in, sleep out, arrive, depart,
    // regulator ready.
    always_comb begin
        ev_hit[0] = I_PWR_FAIL & st.pf_cfg[PF_EN_BIT];
        ev_hit[1] = I_SLEEP_ENTER;
        ev_hit[2] = I_SLEEP_EXIT;
        ev_hit[3] = I_VBUS_PRESENT & ~st.vbus_prev;
        ev_hit[4] = ~I_VBUS_PRESENT & st.vbus_prev;
        ev_hit[5] = I_USB_REG_READY & ~st.usb_rdy_prev;
    end

    always_comb begin
        ev_wr[0] = I_WR && I_ADDR == OFS_PWR_FAIL_EVT;
        ev_wr[1] = I_WR && I_ADDR == OFS_SLEEP_ENTER_EVT;
        ev_wr[2] = I_WR && I_ADDR == OFS_SLEEP_EXIT_EVT;
        ev_wr[3] = I_WR && I_ADDR == OFS_VBUS_DET_EVT;
        ev_wr[4] = I_WR && I_ADDR == OFS_VBUS_REM_EVT;
        ev_wr[5] = I_WR && I_ADDR == OFS_USB_RDY_EVT;
    end

    always_comb begin
        rc_set              = ZERO_WORD;
        rc_set[RC_PIN]      = I_RST_PIN;
        rc_set[RC_WATCHDOG] = I_RST_WATCHDOG;
        rc_set[RC_SOFT]     = I_RST_SOFT;
        rc_set[RC_LOCKUP]   = I_RST_LOCKUP;
        rc_set[RC_GPIO]     = I_WAKE_GPIO;
        rc_set[RC_DEBUG]    = I_WAKE_DEBUG;
        rc_set[RC_VBUS]     = I_WAKE_VBUS;
    end

    // Sections 0,1 form block 0 and sections 2,3 form block 1.
    assign mem_block_on[0] = |I_MEM_SECTION_ON[1:0];
    assign mem_block_on[1] = |I_MEM_SECTION_ON[3:2];

    genvar g;
    generate
        for (g = 0; g < NUM_EVENTS; g++) begin : g_evt
            // A hardware set in the same cycle as a software write wins.
            assign ev_next[g] = ev_hit[g]
                              | (ev_wr[g] ? wr_one : st.events[g]);
        end
    endgenerate

    always_comb begin
        next_st.rdata        = ZERO_WORD;
        next_st.events       = ev_next;
        next_st.int_en       = st.int_en;
        next_st.reset_cause  = st.reset_cause;
        next_st.pf_cfg       = st.pf_cfg;
        next_st.fixed_latency = st.fixed_latency;
        next_st.system_off   = st.system_off;
        next_st.vbus_prev    = I_VBUS_PRESENT;
        next_st.usb_rdy_prev = I_USB_REG_READY;

        if (I_WR) begin
            unique case (I_ADDR)
                OFS_LOW_PWR_TASK: begin
                    if (wr_one) next_st.fixed_latency = 1'b0;
                end
                OFS_FIXED_LAT_TASK: begin
                    if (wr_one) next_st.fixed_latency = 1'b1;
                end
                OFS_INT_EN_SET: begin
                    next_st.int_en = st.int_en
                                   | I_WDATA[NUM_EVENTS-1:0];
                end
                OFS_INT_EN_CLR: begin
                    next_st.int_en = st.int_en
                                   & ~I_WDATA[NUM_EVENTS-1:0];
                end
                OFS_RESET_CAUSE: begin
                    next_st.reset_cause = st.reset_cause
                                        & ~(I_WDATA & RC_MASK);
                end
                OFS_SYSTEM_OFF: begin
                    if (wr_one) next_st.system_off = 1'b1;
                end
                OFS_PF_COMP_CFG: begin
                    next_st.pf_cfg = ZERO_WORD;
                    next_st.pf_cfg[PF_EN_BIT] = I_WDATA[PF_EN_BIT];
                    next_st.pf_cfg[PF_THR_LSB +: PF_THR_W] =
                        I_WDATA[PF_THR_LSB +: PF_THR_W];
                    next_st.pf_cfg[PF_HV_LSB +: PF_HV_W] =
                        I_WDATA[PF_HV_LSB +: PF_HV_W];
                end
                default: begin
                end
            endcase
        end

        // Cause inputs are OR-ed in after the write clear, so a set beats a clear.
        next_st.reset_cause = (next_st.reset_cause | rc_set)
                            & RC_MASK;

        if (I_RD) begin
            unique case (I_ADDR)
                OFS_PWR_FAIL_EVT:    next_st.rdata[0] = st.events[0];
                OFS_SLEEP_ENTER_EVT: next_st.rdata[0] = st.events[1];
                OFS_SLEEP_EXIT_EVT:  next_st.rdata[0] = st.events[2];
                OFS_VBUS_DET_EVT:    next_st.rdata[0] = st.events[3];
                OFS_VBUS_REM_EVT:    next_st.rdata[0] = st.events[4];
                OFS_USB_RDY_EVT:     next_st.rdata[0] = st.events[5];
                OFS_INT_EN_SET,
                OFS_INT_EN_CLR: begin
                    next_st.rdata[NUM_EVENTS-1:0] = st.int_en;
                end
                OFS_RESET_CAUSE:     next_st.rdata = st.reset_cause;
                OFS_MEM_BLOCK_STAT:  next_st.rdata[1:0] = mem_block_on;
                OFS_USB_SUPPLY_STAT: begin
                    next_st.rdata[0] = I_VBUS_PRESENT;
                    next_st.rdata[1] = I_USB_REG_READY;
                end
                OFS_PF_COMP_CFG:     next_st.rdata = st.pf_cfg;
                default:             next_st.rdata = ZERO_WORD;
            endcase
        end

        next_st.irq = |(next_st.events & next_st.int_en);
    end

    // Cause flags are cleared only by a software write of one or the power-on reset
    // outside this block, so the block reset keeps them and ORs in the cause inputs to let them accumulate.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            st.rdata         <= ZERO_WORD;
            st.events        <= '0;
            st.int_en        <= '0;
            st.pf_cfg        <= PF_RESET;
            st.fixed_latency <= 1'b0;
            st.system_off    <= 1'b0;
            st.irq           <= 1'b0;
            st.vbus_prev     <= 1'b0;
            st.usb_rdy_prev  <= 1'b0;
            st.reset_cause   <= (st.reset_cause | rc_set) & RC_MASK;
        end else if (I_CLK_EN) begin
            st <= next_st;
        end
    end

    always_comb begin
        O_RDATA           = st.rdata;
        O_IRQ             = st.irq;
        O_FIXED_LATENCY   = st.fixed_latency;
        O_SYSTEM_OFF      = st.system_off;
        O_PF_ENABLE       = st.pf_cfg[PF_EN_BIT];
        O_PF_THRESHOLD    = st.pf_cfg[PF_THR_LSB +: PF_THR_W];
        O_PF_THRESHOLD_HV = st.pf_cfg[PF_HV_LSB +: PF_HV_W];
    end

    a_irq_follows: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN |=> O_IRQ == |(st.events & st.int_en))
        else $error("irq does not follow enabled events");

    a_en_set: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_WR && I_ADDR == OFS_INT_EN_SET && I_WDATA[0]
        |=> st.int_en[0])
        else $error("enable set write lost");

    a_en_clear: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_WR && I_ADDR == OFS_INT_EN_CLR && I_WDATA[1]
        |=> !st.int_en[1])
        else $error("enable clear write lost");

    a_low_power: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_WR && I_ADDR == OFS_LOW_PWR_TASK && I_WDATA[0]
        |=> !O_FIXED_LATENCY)
        else $error("low power task ignored");

    a_fixed_lat: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_WR && I_ADDR == OFS_FIXED_LAT_TASK && I_WDATA[0]
        |=> O_FIXED_LATENCY)
        else $error("fixed latency task ignored");

    a_sys_off: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_WR && I_ADDR == OFS_SYSTEM_OFF && I_WDATA[0]
        |=> O_SYSTEM_OFF)
        else $error("system off not entered");

    a_cause_sticky: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_RST_PIN |=> st.reset_cause[RC_PIN])
        else $error("pin reset cause lost");

    a_vbus_arrive: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && $rose(I_VBUS_PRESENT) && st.vbus_prev == 1'b0
        |=> st.events[3])
        else $error("vbus arrival event missed");

    a_pf_gate: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && !st.events[0] && !O_PF_ENABLE && !I_WR
        |=> !st.events[0])
        else $error("fail warning set while disabled");

    a_pf_event: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_PWR_FAIL && O_PF_ENABLE |=> st.events[0])
        else $error("power fail warning event missed");

    a_sleep_in: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_SLEEP_ENTER |=> st.events[1])
        else $error("sleep entry event missed");

    a_sleep_out: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_SLEEP_EXIT |=> st.events[2])
        else $error("sleep exit event missed");

    a_vbus_depart: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && !I_VBUS_PRESENT && st.vbus_prev |=> st.events[4])
        else $error("vbus removal event missed");

    a_usb_ready: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_USB_REG_READY && !st.usb_rdy_prev |=> st.events[5])
        else $error("regulator ready event missed");

    a_en_read: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_RD && I_ADDR == OFS_INT_EN_SET
        |=> O_RDATA[NUM_EVENTS-1:0] == $past(st.int_en))
        else $error("enable set read wrong");

    a_en_clr_read: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_RD && I_ADDR == OFS_INT_EN_CLR
        |=> O_RDATA[NUM_EVENTS-1:0] == $past(st.int_en))
        else $error("enable clear read wrong");

    a_cause_clear: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_WR && I_ADDR == OFS_RESET_CAUSE
        && I_WDATA[RC_WATCHDOG] && !I_RST_WATCHDOG
        |=> !st.reset_cause[RC_WATCHDOG])
        else $error("reset cause not cleared by write");

    a_cause_wdog: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_RST_WATCHDOG |=> st.reset_cause[RC_WATCHDOG])
        else $error("watchdog reset cause lost");

    a_cause_soft: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_RST_SOFT |=> st.reset_cause[RC_SOFT])
        else $error("soft reset cause lost");

    a_wake_gpio: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_WAKE_GPIO |=> st.reset_cause[RC_GPIO])
        else $error("gpio wake cause lost");

    a_wake_debug: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_WAKE_DEBUG |=> st.reset_cause[RC_DEBUG])
        else $error("debug wake cause lost");

    a_wake_vbus: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_WAKE_VBUS |=> st.reset_cause[RC_VBUS])
        else $error("vbus wake cause lost");

    a_mem_block: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_RD && I_ADDR == OFS_MEM_BLOCK_STAT
        |=> O_RDATA == {30'h0, $past(|I_MEM_SECTION_ON[3:2]),
                        $past(|I_MEM_SECTION_ON[1:0])})
        else $error("memory block status read wrong");

    a_supply_read: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_RD && I_ADDR == OFS_USB_SUPPLY_STAT
        |=> O_RDATA == {30'h0, $past(I_USB_REG_READY),
                        $past(I_VBUS_PRESENT)})
        else $error("supply status read wrong");

    a_cfg_enable: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_WR && I_ADDR == OFS_PF_COMP_CFG
        |=> O_PF_ENABLE == $past(I_WDATA[PF_EN_BIT]))
        else $error("fail warning enable not written");

    a_cfg_thresh: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_CLK_EN && I_WR && I_ADDR == OFS_PF_COMP_CFG
        |=> O_PF_THRESHOLD == $past(I_WDATA[PF_THR_LSB +: PF_THR_W]))
        else $error("threshold not written");

    a_reset_mode: assert property (
        @(posedge I_SYS_CLK)
        !I_RST_N |=> !O_FIXED_LATENCY && !O_SYSTEM_OFF)
        else $error("reset does not select low power sub-mode");

endmodule : pwr_ctrl_regs

// File: inc/pwr_ctrl_pkg.sv
package pwr_ctrl_pkg;

    localparam int ADDR_W = 12;

    localparam logic [11:0] OFS_FIXED_LAT_TASK  = 12'h078;
    localparam logic [11:0] OFS_LOW_PWR_TASK    = 12'h07c;
    localparam logic [11:0] OFS_PWR_FAIL_EVT    = 12'h108;
    localparam logic [11:0] OFS_SLEEP_ENTER_EVT = 12'h114;
    localparam logic [11:0] OFS_SLEEP_EXIT_EVT  = 12'h118;
    localparam logic [11:0] OFS_VBUS_DET_EVT    = 12'h11c;
    localparam logic [11:0] OFS_VBUS_REM_EVT    = 12'h120;
    localparam logic [11:0] OFS_USB_RDY_EVT     = 12'h124;
    localparam logic [11:0] OFS_INT_EN_SET      = 12'h304;
    localparam logic [11:0] OFS_INT_EN_CLR      = 12'h308;
    localparam logic [11:0] OFS_RESET_CAUSE     = 12'h400;
    localparam logic [11:0] OFS_MEM_BLOCK_STAT  = 12'h428;
    localparam logic [11:0] OFS_USB_SUPPLY_STAT = 12'h438;
    localparam logic [11:0] OFS_SYSTEM_OFF      = 12'h500;
    localparam logic [11:0] OFS_PF_COMP_CFG     = 12'h510;

    localparam int NUM_EVENTS = 6;

    // Reset-cause bit positions.
    localparam int RC_PIN      = 0;
    localparam int RC_WATCHDOG = 1;
    localparam int RC_SOFT     = 2;
    localparam int RC_LOCKUP   = 3;
    localparam int RC_GPIO     = 16;
    localparam int RC_DEBUG    = 18;
    localparam int RC_VBUS     = 20;
    localparam logic [31:0] RC_MASK = 32'h0015000f;

    // Comparator configuration fields.
    localparam int PF_EN_BIT   = 0;
    localparam int PF_THR_LSB  = 1;
    localparam int PF_THR_W    = 4;
    localparam int PF_HV_LSB   = 8;
    localparam int PF_HV_W     = 4;
    localparam logic [31:0] PF_RESET = 32'h00000000;

    localparam logic [31:0] ZERO_WORD = 32'h00000000;

endpackage : pwr_ctrl_pkg

// File: dv/pwr_ctrl_regs_tb_top.sv
module pwr_ctrl_regs_tb_top
    import pwr_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              sys_clk;
    logic              rst_n;
    logic              clk_en;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr_stb;
    logic              rd_stb;
    logic              pwr_fail;
    logic [1:0]        slp;
    logic              vbus;
    logic              usb_rdy;
    logic [6:0]        rc_in;
    logic [3:0]        mem_on;
    logic [31:0]       rdata;
    logic              irq;
    logic              fixed_lat;
    logic              sys_off;
    logic              pf_en;
    logic [3:0]        pf_thr;
    logic [3:0]        pf_hv;
    int                n_fail;
    int                checked;
    logic [31:0]       exp_v;
    logic [31:0]       r;
    logic [31:0]       m;
    int                pos[7] = '{RC_PIN, RC_WATCHDOG, RC_SOFT, RC_LOCKUP,
                                  RC_GPIO, RC_DEBUG, RC_VBUS};

    pwr_ctrl_regs uut (
        .I_SYS_CLK        (sys_clk),
        .I_RST_N          (rst_n),
        .I_CLK_EN         (clk_en),
        .I_ADDR           (addr),
        .I_WDATA          (wdata),
        .I_WR             (wr_stb),
        .I_RD             (rd_stb),
        .I_PWR_FAIL       (pwr_fail),
        .I_SLEEP_ENTER    (slp[0]),
        .I_SLEEP_EXIT     (slp[1]),
        .I_VBUS_PRESENT   (vbus),
        .I_USB_REG_READY  (usb_rdy),
        .I_RST_PIN        (rc_in[0]),
        .I_RST_WATCHDOG   (rc_in[1]),
        .I_RST_SOFT       (rc_in[2]),
        .I_RST_LOCKUP     (rc_in[3]),
        .I_WAKE_GPIO      (rc_in[4]),
        .I_WAKE_DEBUG     (rc_in[5]),
        .I_WAKE_VBUS      (rc_in[6]),
        .I_MEM_SECTION_ON (mem_on),
        .O_RDATA          (rdata),
        .O_IRQ            (irq),
        .O_FIXED_LATENCY  (fixed_lat),
        .O_SYSTEM_OFF     (sys_off),
        .O_PF_ENABLE      (pf_en),
        .O_PF_THRESHOLD   (pf_thr),
        .O_PF_THRESHOLD_HV(pf_hv)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [31:0] mem_status(input logic [3:0] s);
        return {30'h0, |s[3:2], |s[1:0]};
    endfunction : mem_status

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rdchk

    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cycles

    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        end_of_test();
    end

    initial begin
        {rst_n, wr_stb, rd_stb, pwr_fail, slp, vbus, usb_rdy} = '0;
        {rc_in, mem_on, addr, wdata, n_fail, checked} = '0;
        clk_en = 1'b1;
        void'($urandom(32'h3455));
        cycles(12);
        rst_n <= 1'b1;
        wr(OFS_RESET_CAUSE, 32'hffffffff);
        rdchk(OFS_RESET_CAUSE, ZERO_WORD);
        foreach (pos[k]) rdchk(12'h108 + 12'(k * 4), ZERO_WORD);
        rdchk(OFS_INT_EN_SET, ZERO_WORD);
        rdchk(OFS_PF_COMP_CFG, PF_RESET);
        rdchk(OFS_USB_SUPPLY_STAT, ZERO_WORD);
        rdchk(12'h004, ZERO_WORD);
        chk({31'h0, fixed_lat}, 32'h0);
        // Sub-mode tasks; a write of zero must not trigger anything.
        wr(OFS_FIXED_LAT_TASK, 32'h1);
        chk({31'h0, fixed_lat}, 32'h1);
        wr(OFS_LOW_PWR_TASK, 32'h0);
        chk({31'h0, fixed_lat}, 32'h1);
        wr(OFS_LOW_PWR_TASK, 32'h1);
        chk({31'h0, fixed_lat}, 32'h0);
        wr(OFS_SYSTEM_OFF, 32'h0);
        chk({31'h0, sys_off}, 32'h0);
        wr(OFS_SYSTEM_OFF, 32'h1);
        chk({31'h0, sys_off}, 32'h1);
        rdchk(OFS_SYSTEM_OFF, ZERO_WORD);
        // Sleep events: set by pulse, cleared by writing zero.
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            slp[k] <= 1'b1;
            @(posedge sys_clk);
            slp[k] <= 1'b0;
            rdchk(OFS_SLEEP_ENTER_EVT + 12'(k * 4), 32'h1);
            rdchk(OFS_SLEEP_EXIT_EVT - 12'(k * 4), 32'h0);
            wr(OFS_SLEEP_ENTER_EVT + 12'(k * 4), 32'h0);
            rdchk(OFS_SLEEP_ENTER_EVT + 12'(k * 4), 32'h0);
        end
        vbus <= 1'b1;
        rdchk(OFS_VBUS_DET_EVT, 32'h1);
        rdchk(OFS_USB_SUPPLY_STAT, 32'h1);
        rdchk(OFS_VBUS_REM_EVT, 32'h0);
        usb_rdy <= 1'b1;
        rdchk(OFS_USB_RDY_EVT, 32'h1);
        rdchk(OFS_USB_SUPPLY_STAT, 32'h3);
        vbus <= 1'b0;
        rdchk(OFS_VBUS_REM_EVT, 32'h1);
        // Power-fail warning only counts once the enable bit is set.
        pwr_fail <= 1'b1;
        cycles(3);
        rdchk(OFS_PWR_FAIL_EVT, 32'h0);
        wr(OFS_PF_COMP_CFG, 32'h1);
        rdchk(OFS_PWR_FAIL_EVT, 32'h1);
        pwr_fail <= 1'b0;
        wr(OFS_PF_COMP_CFG, 32'h0);
        wr(OFS_PWR_FAIL_EVT, 32'h0);
        rdchk(OFS_PWR_FAIL_EVT, 32'h0);
        for (int i = 0; i < 6; i++) begin
            m = 32'($urandom_range(15, 4));
            exp_v = $urandom & 32'h00000f01;
            wr(OFS_PF_COMP_CFG, exp_v | (m << PF_THR_LSB));
            rdchk(OFS_PF_COMP_CFG, exp_v | (m << PF_THR_LSB));
            chk({28'h0, pf_thr}, m);
            chk({31'h0, pf_en}, {31'h0, exp_v[PF_EN_BIT]});
            chk({28'h0, pf_hv}, {28'h0, exp_v[PF_HV_LSB +: PF_HV_W]});
            mem_on <= 4'($urandom);
            cycles(2);
            exp_v = mem_status(mem_on);
            rdchk(OFS_MEM_BLOCK_STAT, exp_v);
        end
        // Enable set and clear share one state; frozen while clock-gated.
        for (int i = 0; i < 4; i++) begin
            m = $urandom & 32'h3f;
            wr(OFS_INT_EN_CLR, 32'h3f);
            wr(OFS_INT_EN_SET, m);
            wr(OFS_INT_EN_SET, 32'h0);
            rdchk(OFS_INT_EN_SET, m);
            r = $urandom & 32'h3f;
            wr(OFS_INT_EN_CLR, r);
            rdchk(OFS_INT_EN_CLR, m & ~r);
        end
        clk_en <= 1'b0;
        wr(OFS_INT_EN_SET, 32'h3f);
        clk_en <= 1'b1;
        rdchk(OFS_INT_EN_SET, m & ~r);
        wr(OFS_INT_EN_CLR, 32'h3f);
        wr(OFS_INT_EN_SET, 32'h10);
        cycles(2);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_INT_EN_CLR, 32'h10);
        cycles(2);
        chk({31'h0, irq}, 32'h0);
        exp_v = '0;
        foreach (pos[k]) begin
            @(posedge sys_clk);
            rc_in <= 7'(1 << k);
            @(posedge sys_clk);
            rc_in <= '0;
            exp_v[pos[k]] = 1'b1;
            rdchk(OFS_RESET_CAUSE, exp_v);
        end
        wr(OFS_INT_EN_SET, 32'h3f);
        rst_n <= 1'b0;
        cycles(2);
        rst_n <= 1'b1;
        chk({30'h0, sys_off, irq}, 32'h0);
        rdchk(OFS_RESET_CAUSE, exp_v);
        rdchk(OFS_INT_EN_SET, ZERO_WORD);
        r = $urandom & RC_MASK;
        wr(OFS_RESET_CAUSE, r);
        rdchk(OFS_RESET_CAUSE, exp_v & ~r);
        wr(OFS_RESET_CAUSE, 32'hffffffff);
        rdchk(OFS_RESET_CAUSE, ZERO_WORD);
        end_of_test();
    end
endmodule : pwr_ctrl_regs_tb_top
